// >>> pkg/charge_opt_pkg.sv
// Function
// R1 - period code 00 off, 01 is 5 s, 10 is 88 s, 11 is 175 s
// R2 - period field resets to 11, selecting 175 s
// R3 - only charge voltage or charge current writes feed the watchdog
// R4 - on watchdog expiry force charge current setting to zero
// R5 - after expiry restart on current, voltage or period write; run only if valid
// R6 - auto-off set and battery pin low clears input limit loop enable
// R7 - host may write input limit loop enable back to one afterwards
// R8 - option set drives charger ok high during reverse power mode; resets off
// R9 - low power with battery only: linear off, hot, monitors, comparator off
// R10 - converter unavailable while low power mode is active
// R11 - low power cleared: hot, monitors, comparator follow their own settings
// R12 - in low power, comparator still on if opt1 bit 6 or 5 set
// R13 - out of audio bit keeps burst floor above 25 kHz; resets to one
// R14 - frequency bit 0 selects 1200 kHz, 1 selects 800 kHz; resets to one
// R15 - host sets frequency bit to match inductor after every power on
// R16 - ripple reduce bit enables pass through ripple reduction; resets to one
// R17 - paired bytes dropped when low to high gap exceeds watchdog period
// R18 - loop enable resets to one and reads zero after automatic clear
// R19 - block bit zero lets valid settings charge; one inhibits charging
// R20 - accepted current or voltage write restarts count; disabled holds it clear
package charge_opt_pkg;
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          WD_T5_S       = 5;
    localparam int          WD_T88_S      = 88;
    localparam int          WD_T175_S     = 175;
    localparam logic [6:0]  TARGET_ADDR   = 7'h09;
    localparam logic [7:0]  A_OPT0_LO     = 8'h00;
    localparam logic [7:0]  A_OPT0_HI     = 8'h01;
    localparam logic [7:0]  A_CUR_LO      = 8'h02;
    localparam logic [7:0]  A_CUR_HI      = 8'h03;
    localparam logic [7:0]  A_VOLT_LO     = 8'h04;
    localparam logic [7:0]  A_VOLT_HI     = 8'h05;
    localparam logic [7:0]  A_OPT1_HI     = 8'h31;
    localparam logic [15:0] OPT0_RESET    = 16'hE70E;
    localparam logic [15:0] CUR_RESET     = 16'h0000;
    localparam logic [15:0] VOLT_RESET    = 16'h0000;
    localparam logic [7:0]  OPT1_HI_RESET = 8'h02;
    localparam logic [15:0] CUR_MASK      = 16'h1FC0;
    localparam logic [15:0] VOLT_MASK     = 16'h7FF8;
    localparam int          F_LOW_POWER   = 15;
    localparam int          F_WD_HI       = 14;
    localparam int          F_WD_LO       = 13;
    localparam int          F_AUTO_OFF    = 12;
    localparam int          F_OTG_OK      = 11;
    localparam int          F_OOA         = 10;
    localparam int          F_FREQ        = 9;
    localparam int          F_RIPPLE      = 8;
    localparam int          F_LIMIT_EN    = 1;
    localparam int          F_BLOCK       = 0;
    localparam int          F_CMP_A       = 6;
    localparam int          F_CMP_B       = 5;
    localparam logic [1:0]  WD_OFF        = 2'h0;
    localparam logic [1:0]  WD_5S         = 2'h1;
    localparam logic [1:0]  WD_88S        = 2'h2;
    localparam logic [3:0]  BITS_BYTE     = 4'h8;
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_PTR, S_WDATA, S_RDATA, S_MACK} i2c_state_t;
endpackage

// >>> hw/charge_option_ctrl_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module charge_option_ctrl_watchdog
    import charge_opt_pkg::*;
#(
    parameter logic [30:0] WD_CYC_5S   = 31'(WD_T5_S * CLK_HZ),
    parameter logic [30:0] WD_CYC_88S  = 31'(WD_T88_S * CLK_HZ),
    parameter logic [30:0] WD_CYC_175S = 31'(WD_T175_S * CLK_HZ)
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // two-wire host port
    input  wire logic scl,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // device status inputs
    input  wire logic battery_present_n,
    input  wire logic adapter_present,
    input  wire logic adapter_ok,
    input  wire logic reverse_power_mode,
    input  wire logic hot_cfg_en,
    input  wire logic monitor_cfg_en,
    input  wire logic comparator_cfg_en,
    input  wire logic adc_req,
    // control outputs
    output logic      charger_ok_out,
    output logic      linear_on,
    output logic      hot_logic_en,
    output logic      monitor_buf_en,
    output logic      comparator_en,
    output logic      adc_start,
    output logic      adc_reject,
    output logic      burst_floor_en,
    output logic      switching_freq_800k,
    output logic      ripple_reduce_en,
    output logic      input_limit_loop_enable,
    output logic      charge_run,
    output logic      watchdog_expired
);
    ////////////////////////////////////////////////////////////////////////////
    logic              rst_a_ff, rst_n;
    logic              scl_q_ff, sda_q_ff, batp_q_ff;
    i2c_state_t        state_ff;
    logic [3:0]        cnt_ff;
    logic [7:0]        shreg_ff, tx_ff, ptr_ff, rdata;
    logic              ack_ff, wr_stb_ff;
    logic [7:0]        wr_addr_ff, wr_data_ff;
    logic [15:0]       opt0_ff, cur_ff, volt_ff;
    logic [7:0]        opt1_hi_ff;
    logic              pend_ff;
    logic [7:0]        pend_addr_ff, pend_data_ff;
    logic [30:0]       gap_cnt_ff, wd_cnt_ff, wd_limit;
    logic              expired_ff;
    logic              scl_rise, scl_fall, i2c_start, i2c_stop;
    logic              commit_cur, commit_volt, restart, wd_on, batp_fall, lp_active;
    logic [1:0]        wd_sel;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_a_ff <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_a_ff <= 1'b1;
            rst_n    <= rst_a_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // two-wire target: pointer byte, auto-incrementing writes and reads
    assign scl_rise  = scl & ~scl_q_ff;
    assign scl_fall  = ~scl & scl_q_ff;
    assign i2c_start = scl & scl_q_ff & sda_q_ff & ~sda_in;
    assign i2c_stop  = scl & scl_q_ff & ~sda_q_ff & sda_in;
    assign sda_out   = 1'b0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q_ff  <= 1'b1;
            sda_q_ff  <= 1'b1;
            batp_q_ff <= 1'b1;
        end else begin
            scl_q_ff  <= scl;
            sda_q_ff  <= sda_in;
            batp_q_ff <= battery_present_n;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff   <= S_IDLE;
            cnt_ff     <= 4'h0;
            shreg_ff   <= 8'h00;
            tx_ff      <= 8'h00;
            ptr_ff     <= 8'h00;
            ack_ff     <= 1'b0;
            sda_oe     <= 1'b0;
            wr_stb_ff  <= 1'b0;
            wr_addr_ff <= 8'h00;
            wr_data_ff <= 8'h00;
        end else begin
            wr_stb_ff <= 1'b0;
            if (i2c_start) begin
                state_ff <= S_ADDR;
                cnt_ff   <= 4'h0;
                ack_ff   <= 1'b0;
                sda_oe   <= 1'b0;
            end else if (i2c_stop) begin
                state_ff <= S_IDLE;
                ack_ff   <= 1'b0;
                sda_oe   <= 1'b0;
            end else if (state_ff == S_MACK) begin
                if (scl_rise) begin
                    state_ff <= sda_in ? S_IDLE : S_RDATA;
                    ack_ff   <= ~sda_in;
                end
            end else if (scl_rise && !ack_ff && cnt_ff < BITS_BYTE
                         && state_ff != S_RDATA && state_ff != S_IDLE) begin
                shreg_ff <= {shreg_ff[6:0], sda_in};
                cnt_ff   <= cnt_ff + 4'h1;
            end else if (scl_fall && ack_ff) begin
                ack_ff <= 1'b0;
                cnt_ff <= 4'h0;
                sda_oe <= 1'b0;
                if (state_ff == S_RDATA) begin
                    tx_ff  <= rdata;
                    sda_oe <= ~rdata[7];
                    cnt_ff <= 4'h1;
                end
            end else if (scl_fall && state_ff == S_RDATA) begin
                if (cnt_ff == BITS_BYTE) begin
                    sda_oe   <= 1'b0;
                    state_ff <= S_MACK;
                    ptr_ff   <= ptr_ff + 8'h01;
                end else begin
                    sda_oe <= ~tx_ff[6];
                    tx_ff  <= {tx_ff[6:0], 1'b0};
                    cnt_ff <= cnt_ff + 4'h1;
                end
            end else if (scl_fall && cnt_ff == BITS_BYTE) begin
                ack_ff <= 1'b1;
                sda_oe <= 1'b1;
                case (state_ff)
                    S_ADDR: begin
                        if (shreg_ff[7:1] == TARGET_ADDR) begin
                            state_ff <= shreg_ff[0] ? S_RDATA : S_PTR;
                        end else begin
                            state_ff <= S_IDLE;
                            ack_ff   <= 1'b0;
                            sda_oe   <= 1'b0;
                        end
                    end
                    S_PTR: begin
                        ptr_ff   <= shreg_ff;
                        state_ff <= S_WDATA;
                    end
                    S_WDATA: begin
                        wr_stb_ff  <= 1'b1;
                        wr_addr_ff <= ptr_ff;
                        wr_data_ff <= shreg_ff;
                        ptr_ff     <= ptr_ff + 8'h01;
                    end
                    default: begin
                        ack_ff <= 1'b0;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    always_comb begin
        case (ptr_ff)
            A_OPT0_LO: rdata = opt0_ff[7:0];
            A_OPT0_HI: rdata = opt0_ff[15:8];
            A_CUR_LO:  rdata = cur_ff[7:0];
            A_CUR_HI:  rdata = cur_ff[15:8];
            A_VOLT_LO: rdata = volt_ff[7:0];
            A_VOLT_HI: rdata = volt_ff[15:8];
            A_OPT1_HI: rdata = opt1_hi_ff;
            default:   rdata = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // paired-byte settings: low byte staged, high byte commits both
    assign wd_sel    = opt0_ff[F_WD_HI:F_WD_LO];
    assign wd_on     = wd_sel != WD_OFF;                                           // [R1]
    assign wd_limit  = (wd_sel == WD_5S) ? WD_CYC_5S :
                       (wd_sel == WD_88S) ? WD_CYC_88S : WD_CYC_175S;              // [R1]
    assign commit_cur  = wr_stb_ff && wr_addr_ff == A_CUR_HI && pend_ff
                         && pend_addr_ff == A_CUR_LO;
    assign commit_volt = wr_stb_ff && wr_addr_ff == A_VOLT_HI && pend_ff
                         && pend_addr_ff == A_VOLT_LO;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff      <= 1'b0;
            pend_addr_ff <= 8'h00;
            pend_data_ff <= 8'h00;
            gap_cnt_ff   <= 31'h0;
        end else if (wr_stb_ff) begin
            pend_ff      <= wr_addr_ff == A_CUR_LO || wr_addr_ff == A_VOLT_LO;
            pend_addr_ff <= wr_addr_ff;
            pend_data_ff <= wr_data_ff;
            gap_cnt_ff   <= 31'h0;
        end else if (pend_ff && wd_on) begin
            if (gap_cnt_ff >= wd_limit - 31'h1) begin
                pend_ff <= 1'b0;                                                   // [R17]
            end else begin
                gap_cnt_ff <= gap_cnt_ff + 31'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // watchdog over charge setting writes
    assign restart = commit_cur || commit_volt
                     || (expired_ff && wr_stb_ff && wr_addr_ff == A_OPT0_HI);      // [R3] [R5]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_cnt_ff  <= 31'h0;
            expired_ff <= 1'b0;
        end else if (restart) begin
            wd_cnt_ff  <= 31'h0;                                                   // [R20]
            expired_ff <= 1'b0;                                                    // [R5]
        end else if (!wd_on) begin
            wd_cnt_ff <= 31'h0;                                                    // [R20]
        end else if (!expired_ff) begin
            if (wd_cnt_ff >= wd_limit - 31'h1) begin
                wd_cnt_ff  <= 31'h0;
                expired_ff <= 1'b1;                                                // [R4]
            end else begin
                wd_cnt_ff <= wd_cnt_ff + 31'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register file
    assign batp_fall = batp_q_ff & ~battery_present_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opt0_ff    <= OPT0_RESET;                                              // [R2] [R18]
            cur_ff     <= CUR_RESET;
            volt_ff    <= VOLT_RESET;
            opt1_hi_ff <= OPT1_HI_RESET;
        end else begin
            if (wr_stb_ff && wr_addr_ff == A_OPT0_LO) begin
                opt0_ff[7:0] <= wr_data_ff;                                        // [R7]
            end
            if (wr_stb_ff && wr_addr_ff == A_OPT0_HI) begin
                opt0_ff[15:8] <= wr_data_ff;
            end
            if (wr_stb_ff && wr_addr_ff == A_OPT1_HI) begin
                opt1_hi_ff <= wr_data_ff;
            end
            if (batp_fall && opt0_ff[F_AUTO_OFF]) begin
                opt0_ff[F_LIMIT_EN] <= 1'b0;                                       // [R6] [R18]
            end
            if (commit_cur) begin
                cur_ff <= {wr_data_ff, pend_data_ff} & CUR_MASK;
            end else if (wd_on && !expired_ff && !restart
                         && wd_cnt_ff >= wd_limit - 31'h1) begin
                cur_ff <= 16'h0000;                                                // [R4]
            end
            if (commit_volt) begin
                volt_ff <= {wr_data_ff, pend_data_ff} & VOLT_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control outputs
    assign lp_active = opt0_ff[F_LOW_POWER] & ~adapter_present;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            charger_ok_out          <= 1'b0;
            linear_on               <= 1'b0;
            hot_logic_en            <= 1'b0;
            monitor_buf_en          <= 1'b0;
            comparator_en           <= 1'b0;
            adc_start               <= 1'b0;
            adc_reject              <= 1'b0;
            burst_floor_en          <= 1'b1;
            switching_freq_800k     <= 1'b1;
            ripple_reduce_en        <= 1'b1;
            input_limit_loop_enable <= 1'b1;
            charge_run              <= 1'b0;
            watchdog_expired        <= 1'b0;
        end else begin
            charger_ok_out <= adapter_ok | (opt0_ff[F_OTG_OK] & reverse_power_mode); // [R8]
            linear_on      <= ~lp_active;                                          // [R9]
            hot_logic_en   <= ~lp_active & hot_cfg_en;                             // [R9] [R11]
            monitor_buf_en <= ~lp_active & monitor_cfg_en;                         // [R9] [R11]
            comparator_en  <= lp_active ? (opt1_hi_ff[F_CMP_A] | opt1_hi_ff[F_CMP_B])
                                        : comparator_cfg_en;                       // [R12] [R11]
            adc_start      <= adc_req & ~lp_active;                                // [R10]
            adc_reject     <= adc_req & lp_active;                                 // [R10]
            burst_floor_en      <= opt0_ff[F_OOA];                                 // [R13]
            switching_freq_800k <= opt0_ff[F_FREQ];                                // [R14]
            ripple_reduce_en    <= opt0_ff[F_RIPPLE];                              // [R16]
            input_limit_loop_enable <= opt0_ff[F_LIMIT_EN];
            charge_run <= ~opt0_ff[F_BLOCK] && cur_ff != 16'h0000
                          && volt_ff != 16'h0000;                                  // [R19] [R5]
            watchdog_expired <= expired_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_lsb_staged;
        pend_ff && pend_addr_ff == A_CUR_LO;
    endsequence
    sequence s_msb_wr;
        wr_stb_ff && wr_addr_ff == A_CUR_HI;
    endsequence

    property p_pair_commit;
        @(posedge clk) disable iff (!rst_n)
        s_lsb_staged ##0 s_msb_wr
        |=> cur_ff == ({$past(wr_data_ff), $past(pend_data_ff)} & CUR_MASK)
                         && wd_cnt_ff == 31'h0;
    endproperty
    a_pair_commit: assert property (p_pair_commit) else $error("paired write not committed"); // [R20]

    property p_msb_alone;
        @(posedge clk) disable iff (!rst_n)
        s_msb_wr ##0 (!pend_ff && !expired_ff && wd_cnt_ff < wd_limit - 31'h1)
        |=> $stable(cur_ff);
    endproperty
    a_msb_alone: assert property (p_msb_alone) else $error("unpaired high byte changed current"); // [R17]

    property p_wd_expire;
        @(posedge clk) disable iff (!rst_n)
        wd_on && !expired_ff && !restart && wd_cnt_ff == wd_limit - 31'h1
        |=> expired_ff && cur_ff == 16'h0000 ##1 watchdog_expired;
    endproperty
    a_wd_expire: assert property (p_wd_expire) else $error("watchdog expiry missed"); // [R4]

    property p_wd_off;
        @(posedge clk) disable iff (!rst_n)
        !wd_on |=> wd_cnt_ff == 31'h0;
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("disabled watchdog still counting"); // [R20]

    property p_auto_off;
        @(posedge clk) disable iff (!rst_n)
        batp_fall && opt0_ff[F_AUTO_OFF] |=> !opt0_ff[F_LIMIT_EN] ##1 !input_limit_loop_enable;
    endproperty
    a_auto_off: assert property (p_auto_off) else $error("loop enable not auto cleared"); // [R6]

    property p_otg_ok;
        @(posedge clk) disable iff (!rst_n)
        opt0_ff[F_OTG_OK] && reverse_power_mode |=> charger_ok_out;
    endproperty
    a_otg_ok: assert property (p_otg_ok) else $error("charger ok low in reverse power"); // [R8]

    property p_adc_lp;
        @(posedge clk) disable iff (!rst_n)
        adc_req && lp_active |=> adc_reject && !adc_start;
    endproperty
    a_adc_lp: assert property (p_adc_lp) else $error("converter ran in low power"); // [R10]

    property p_cmp_lp;
        @(posedge clk) disable iff (!rst_n)
        lp_active && (opt1_hi_ff[F_CMP_A] || opt1_hi_ff[F_CMP_B]) |=> comparator_en && !linear_on;
    endproperty
    a_cmp_lp: assert property (p_cmp_lp) else $error("comparator off in low power"); // [R12]

    property p_defaults;
        @(posedge clk) $rose(rst_n) |-> opt0_ff == OPT0_RESET && wd_cnt_ff == 31'h0;
    endproperty
    a_defaults: assert property (p_defaults) else $error("bad option defaults"); // [R2]
endmodule
`default_nettype wire

// >>> sim/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model
    import charge_opt_pkg::*;
(
    // bus
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      pull,
    // status
    output logic      ok
);
    initial begin
        scl = 1'b1;
        pull = 1'b0;
        ok = 1'b1;
    end
    task automatic drv(input logic c, input logic p);
        repeat (4) @(posedge clk);
        scl <= c;
        pull <= p;
    endtask
    // data moves only while the clock is low
    task automatic xbit(input logic b, output logic r);
        drv(1'b0, !b);
        drv(1'b1, !b);
        repeat (2) @(posedge clk);
        r = sda;
        drv(1'b0, !b);
    endtask
    task automatic xbyte(input logic [7:0] d, input logic w, output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], q[i]);
        end
        // ninth bit: host releases the line, giving nack on reads
        xbit(1'b1, r);
        if (w) ok = ok & !r;
    endtask
    task automatic sta();
        drv(1'b0, 1'b0);
        drv(1'b1, 1'b0);
        drv(1'b1, 1'b1);
    endtask
    task automatic sto();
        drv(1'b0, 1'b1);
        drv(1'b1, 1'b1);
        drv(1'b1, 1'b0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        ok = 1'b1;
        sta();
        xbyte({TARGET_ADDR, 1'b0}, 1'b1, q);
        xbyte(a, 1'b1, q);
        xbyte(d, 1'b1, q);
        sto();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] q;
        ok = 1'b1;
        sta();
        xbyte({TARGET_ADDR, 1'b0}, 1'b1, q);
        xbyte(a, 1'b1, q);
        sta();
        xbyte({TARGET_ADDR, 1'b1}, 1'b1, q);
        xbyte(8'hFF, 1'b0, d);
        sto();
    endtask
endmodule
`default_nettype wire

// >>> sim/charge_option_ctrl_watchdog_tb.sv
`timescale 1ns/1ps
`default_nettype none
module charge_option_ctrl_watchdog_tb
    import charge_opt_pkg::*;
;
    localparam int W1 = 1500;
    localparam int W2 = 2500;
    localparam int W3 = 4000;
    logic clk = 1'b0;
    logic nrst, scl, pull, ok, sda_oe, adc_s, adc_r, battery_present_n, adc_req;
    logic adapter_ok, reverse_power_mode, hot_cfg_en, monitor_cfg_en, comparator_cfg_en;
    logic adapter_present;
    logic [10:0] o;
    logic [31:0] rs = 32'h002AF6B2;
    int m [int];
    int pl = -9;
    int pd, err_count, n_tests, cnt;
    logic wd_x = 1'b0;
    int ra [4] = '{1, 0, 49, 127};
    wire sda = !(sda_oe | pull);
    always #50 clk = ~clk;
    i2c_host_model host (.clk(clk), .sda(sda), .scl(scl), .pull(pull), .ok(ok));
    charge_option_ctrl_watchdog #(.WD_CYC_5S(31'(W1)), .WD_CYC_88S(31'(W2)),
        .WD_CYC_175S(31'(W3))) DUT (.clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda),
        .sda_out(), .sda_oe(sda_oe), .battery_present_n(battery_present_n),
        .adapter_present(adapter_present), .adapter_ok(adapter_ok),
        .reverse_power_mode(reverse_power_mode), .hot_cfg_en(hot_cfg_en),
        .monitor_cfg_en(monitor_cfg_en), .comparator_cfg_en(comparator_cfg_en),
        .adc_req(adc_req), .charger_ok_out(o[10]), .linear_on(o[9]), .hot_logic_en(o[8]),
        .monitor_buf_en(o[7]), .comparator_en(o[6]), .adc_start(adc_s), .adc_reject(adc_r),
        .burst_floor_en(o[5]), .switching_freq_800k(o[4]), .ripple_reduce_en(o[3]),
        .input_limit_loop_enable(o[2]), .charge_run(o[1]), .watchdog_expired(o[0]));
    function automatic int rv(input int a);
        return m.exists(a) ? m[a] : 0;
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [10:0] expv();
        int m0 = rv(0);
        int m1 = rv(1);
        int m3 = rv(49);
        logic lp = m1[7] & !adapter_present;
        return {adapter_ok | (m1[3] & reverse_power_mode), !lp, hot_cfg_en & !lp,
            monitor_cfg_en & !lp, lp ? (m3[6] | m3[5]) : comparator_cfg_en, m1[2], m1[1],
            m1[0], m0[1], !m0[0] && (rv(2) | rv(3)) != 0 && (rv(4) | rv(5)) != 0, wd_x};
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rc(input int a);
        logic [7:0] q;
        host.rd(8'(a), q);
        chk(16'(q), 16'(rv(a)));
    endtask
    // low byte is staged, matching high byte commits the masked pair
    task automatic mw(input int a, input int d);
        int v;
        host.wr(8'(a), 8'(d));
        chk(16'(ok), 16'h0001);
        if (a == 2 || a == 4) begin
            pl = a;
            pd = d;
        end else begin
            if (a == pl + 1) begin
                v = ((d << 8) | pd) & int'(a == 3 ? CUR_MASK : VOLT_MASK);
                m[pl] = v & 255;
                m[a] = v >> 8;
                wd_x = 1'b0;
            end else if (a < 2 || a == 49) m[a] = d;
            if (a == 1) wd_x = 1'b0;
            pl = -9;
        end
    endtask
    task automatic end_sim();
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        nrst = 1'b0;
        adc_req = 1'b0;
        battery_present_n = 1'b1;
        {adapter_ok, reverse_power_mode, hot_cfg_en, monitor_cfg_en, comparator_cfg_en,
            adapter_present} = 6'h01;
        m[0] = 8'h0E;
        m[1] = 8'hE7;
        m[49] = 8'h02;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        chk(16'(o), 16'(expv()));
        foreach (ra[i]) rc(ra[i]);
        mw(1, 8'h06);
        for (int i = 0; i < 8; i++) begin
            rs = lfsr(rs);
            @(posedge clk);
            {adapter_ok, reverse_power_mode, hot_cfg_en, monitor_cfg_en, comparator_cfg_en,
                adapter_present} <= rs[5:0];
            mw(49, rs[15:8]);
            mw(1, {i[0], 3'h0, rs[19:16]});
            chk(16'(o), 16'(expv()));
            @(posedge clk);
            adc_req <= 1'b1;
            @(posedge clk);
            adc_req <= 1'b0;
            #1;
            chk({adc_s, adc_r}, (rv(1) >> 7) & !adapter_present ? 16'h0001 : 16'h0002);
            rc(1);
        end
        mw(2, 8'hC0);
        mw(3, 8'h0F);
        mw(4, 8'hF8);
        mw(5, 8'h10);
        mw(3, 8'h55);
        for (int a = 2; a < 6; a++) rc(a);
        mw(1, 8'h16);
        mw(0, 8'h0F);
        chk(16'(o), 16'(expv()));
        battery_present_n <= 1'b0;
        repeat (4) @(posedge clk);
        m[0] = 8'h0D;
        chk(16'(o), 16'(expv()));
        rc(0);
        mw(0, 8'h0E);
        chk(16'(o), 16'(expv()));
        for (int c = 1; c < 4; c++) begin
            mw(1, (c << 5) | 6);
            for (int j = 0; j < 3; j++) begin
                mw(2, 8'h40);
                mw(3, j + 1);
            end
            chk(16'(o), 16'(expv()));
            for (cnt = 0; cnt < 5000 && o[0] !== 1'b1; cnt++) @(posedge clk);
            v_lim(c);
            m[2] = 0;
            m[3] = 0;
            wd_x = 1'b1;
            chk(16'(o), 16'(expv()));
            rc(3);
        end
        // low byte staged, then a gap longer than the period drops the pair
        mw(4, 8'h10);
        repeat (W3) @(posedge clk);
        pl = -9;
        mw(5, 8'h30);
        rc(5);
        mw(1, 8'h26);
        chk(16'(o), 16'(expv()));
        mw(4, 8'h08);
        for (int k = 0; k < 8 && o[0] !== 1'b1; k++) mw(49, 8'h02);
        wd_x = 1'b1;
        chk(16'(o), 16'(expv()));
        mw(5, 8'h20);
        rc(4);
        mw(2, 8'h80);
        mw(3, 8'h01);
        chk(16'(o), 16'(expv()));
        mw(1, 8'h06);
        repeat (W3 + 100) @(posedge clk);
        chk(16'(o), 16'(expv()));
        end_sim();
    end
    task automatic v_lim(input int c);
        int n = c == 1 ? W1 : c == 2 ? W2 : W3;
        chk(16'(cnt >= n - 40 && cnt <= n + 4), 16'h0001);
    endtask
endmodule
`default_nettype wire
